//--- core/wake_control_pkg.sv
package wake_control_pkg;

	// Core register byte addresses.
	localparam logic [23:0] ADDR_CONTROL_STATUS_ONE          = 24'hFFF040;
	localparam logic [23:0] ADDR_CONTROL_STATUS_TWO          = 24'hFFF042;
	localparam logic [23:0] ADDR_CONTROL_STATUS_THREE        = 24'hFFF044;
	localparam logic [23:0] ADDR_CONFIG_BASE_LOW             = 24'hFFF048;
	localparam logic [23:0] ADDR_CONFIG_BASE_HIGH            = 24'hFFF04A;
	localparam logic [23:0] ADDR_CORE_INTERRUPT_ENABLE_TWO   = 24'hFFF04C;
	localparam logic [23:0] ADDR_CORE_EVENT_STATUS           = 24'hFFF04E;
	localparam logic [23:0] ADDR_CORE_EVENT_INTERRUPT_ENABLE = 24'hFFF050;

	// Host register offsets and the bank that holds event routing.
	localparam logic [4:0] HOST_OFS_EVENT_STATUS  = 5'h00;
	localparam logic [4:0] HOST_OFS_STATE_REQUEST = 5'h07;
	localparam logic [4:0] HOST_OFS_SMI_ROUTING   = 5'h13;
	localparam logic [4:0] HOST_OFS_IRQ_ROUTING   = 5'h15;
	localparam logic [4:0] HOST_OFS_BANKED_FIRST  = 5'h13;
	localparam logic [1:0] HOST_ROUTING_BANK      = 2'h2;

	// Field positions.
	localparam int BIT_GATE_CONTROL   = 7;
	localparam int BIT_CLEAR_MODE     = 5;
	localparam int BIT_CONFIG_LOCK    = 4;
	localparam int BIT_BASE_VALID     = 3;
	localparam int BIT_BUS_RESET      = 2;
	localparam int BIT_SUPPLY_ON      = 1;
	localparam int BIT_RESET_FORCE    = 0;
	localparam int BIT_POWER_OFF      = 7;
	localparam int BIT_BUTTON_MODE    = 6;
	localparam int BIT_SLEEP_HIGH     = 5;
	localparam int BIT_SLEEP_LOW      = 1;
	localparam int BIT_WORKING        = 0;
	localparam int BIT_OVERRIDE       = 1;
	localparam int BIT_EARLY_RESET    = 0;
	localparam int BIT_MODULE_EVENT   = 7;
	localparam int BIT_SOFTWARE_EVENT = 6;
	localparam int BIT_BASE_ALIGN     = 0;

	// Reset values.
	localparam logic [7:0] RESET_CONTROL_STATUS_THREE = 8'h09;
	localparam logic [7:0] RESET_ZERO                 = 8'h00;
	localparam logic       RESET_GATE_CONTROL         = 1'b1;

	// Core register access strobe group.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} core_access_type;

	// Host register access strobe group.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] bank;
		logic [4:0] offset;
		logic [7:0] wdata;
	} host_access_type;

	// Whole state of the block.
	typedef struct packed {
		logic       gate_control;
		logic       clear_mode;
		logic       config_lock;
		logic       base_valid;
		logic       host_reset_force;
		logic       power_off_request;
		logic       power_button_mode_mirror;
		logic       button_mode_change;
		logic [5:0] state_requests;
		logic [7:0] control_status_three;
		logic [7:0] config_base_low;
		logic [7:0] config_base_high;
		logic [7:0] core_interrupt_enable_two;
		logic [7:0] core_event_status;
		logic [7:0] core_event_interrupt_enable;
		logic       host_software_event;
		logic [7:0] smi_routing_enable;
		logic [7:0] irq_routing_enable;
		logic [7:0] core_rdata;
		logic [7:0] host_rdata;
		logic       gate_a_twenty_output;
		logic       keyboard_reset_n;
		logic       smi_n;
		logic       host_irq;
		logic       state_request_wake;
		logic       status_interrupt;
		logic       event_interrupt;
		logic       bus_reset_active;
		logic       config_enable;
	} wake_state_type;

endpackage

//--- core/wake_control_unit.sv
// Behaviour
// - S1-S5 write requests; reads return zero
// - Host Sn write sets matching sleep latch
// - All S1-S5 zero sets working latch
// - Core write one clears request latch
// - Any request latch raises core wake
// - SMI routing bit 6, resets disabled
// - IRQ routing bit 6, resets zero
// - Gate control bit drives gate output
// - Mode 0: toggle, rise sets core
// - Mode 1: core clear clears both
// - Lock sticks, freezes base fields
// - Base valid: write one clears
// - Base valid enables host decode
// - Bus reset active mirrors reset, read in control one
// - Reset force holds keyboard reset low
// - Power off request set, W1C
// - Button mode mirror, change interrupt
// - Override forces gate and keyboard reset low in powerdown
// - Early bus activity causes keyboard reset
// - Base low bit 0 always zero
// - Enables give level status interrupt
// - Interrupt drops with status or enable
`timescale 1ns/1ps
module wake_control_unit #(
	parameter int CORE_ADDR_WIDTH = 24
) (
	input  wire logic                                    ref_clk,
	input  wire logic                                    rst,
	input  wire logic                                    supply_por,
	input  wire wake_control_pkg::core_access_type       core_access,
	output logic [7:0]                                   core_rdata,
	input  wire wake_control_pkg::host_access_type       host_access,
	output logic [7:0]                                   host_rdata,
	input  wire logic                                    host_power_off_write,
	input  wire logic                                    host_button_mode,
	input  wire logic                                    module_irq_event,
	input  wire logic                                    host_supply_on,
	input  wire logic                                    lpc_reset_n,
	input  wire logic                                    lpc_powerdown_n,
	input  wire logic                                    lpc_activity,
	output logic                                         gate_a_twenty_output,
	output logic                                         keyboard_reset_n,
	output logic                                         smi_n,
	output logic                                         host_irq,
	output logic                                         state_request_wake,
	output logic                                         status_interrupt,
	output logic                                         event_interrupt,
	output logic                                         bus_reset_active,
	output logic                                         config_enable,
	output logic [15:0]                                  config_base
);

	// The core map is fixed at 24-bit addresses.
	if (CORE_ADDR_WIDTH != 24) begin : g_width_check
		$error("wake_control_unit: CORE_ADDR_WIDTH must be 24");
	end

	wake_control_pkg::wake_state_type state_reg;
	wake_control_pkg::wake_state_type state_next;

	// One-cycle core write decode.
	function automatic logic core_hit(input wake_control_pkg::core_access_type acc,
			input logic [23:0] addr);
		core_hit = acc.wr && (acc.addr == addr);
	endfunction

	// Host routing registers only exist in the routing bank.
	function automatic logic host_hit(input wake_control_pkg::host_access_type acc,
			input logic [4:0] ofs);
		logic banked;
		banked = (ofs >= wake_control_pkg::HOST_OFS_BANKED_FIRST);
		host_hit = (acc.offset == ofs)
			&& (!banked || acc.bank == wake_control_pkg::HOST_ROUTING_BANK);
	endfunction

	always_comb begin
		logic [7:0] wd;
		logic [7:0] hd;
		logic       state_wr;
		logic       event_rise;
		logic       core_event_clear;
		logic       powerdown_force;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		wd               = core_access.wdata;
		hd               = host_access.wdata;
		state_next       = state_reg;
		state_wr         = host_access.wr
			&& host_hit(host_access, wake_control_pkg::HOST_OFS_STATE_REQUEST);
		event_rise       = 1'b0;
		core_event_clear = 1'b0;
		ctl1             = '0;
		ctl2             = '0;
		powerdown_force  = 1'b0;

		// Control status one: gate, clear mode, lock, base valid, reset force.
		if (core_hit(core_access, wake_control_pkg::ADDR_CONTROL_STATUS_ONE)) begin
			state_next.gate_control     = wd[wake_control_pkg::BIT_GATE_CONTROL];
			state_next.clear_mode       = wd[wake_control_pkg::BIT_CLEAR_MODE];
			state_next.host_reset_force = wd[wake_control_pkg::BIT_RESET_FORCE];
			if (wd[wake_control_pkg::BIT_CONFIG_LOCK]) begin
				state_next.config_lock = 1'b1;
			end
			// The lock taken in the same write does not yet guard this bit.
			if (!state_reg.config_lock
					&& wd[wake_control_pkg::BIT_BASE_VALID]) begin
				state_next.base_valid = 1'b0;
			end
		end

		// Power-state requests from the host; host reads of the request offset give zero.
		if (core_hit(core_access, wake_control_pkg::ADDR_CONTROL_STATUS_TWO)) begin
			state_next.state_requests = state_reg.state_requests
				& ~wd[wake_control_pkg::BIT_SLEEP_HIGH:wake_control_pkg::BIT_WORKING];
			if (wd[wake_control_pkg::BIT_POWER_OFF]) begin
				state_next.power_off_request = 1'b0;
			end
			if (wd[wake_control_pkg::BIT_BUTTON_MODE]) begin
				state_next.button_mode_change = 1'b0;
			end
		end
		if (state_wr) begin
			state_next.state_requests[wake_control_pkg::BIT_SLEEP_HIGH:
				wake_control_pkg::BIT_SLEEP_LOW] =
				state_next.state_requests[wake_control_pkg::BIT_SLEEP_HIGH:
				wake_control_pkg::BIT_SLEEP_LOW]
				| hd[wake_control_pkg::BIT_SLEEP_HIGH:wake_control_pkg::BIT_SLEEP_LOW];
			if (hd[wake_control_pkg::BIT_SLEEP_HIGH:wake_control_pkg::BIT_SLEEP_LOW]
					== '0) begin
				state_next.state_requests[wake_control_pkg::BIT_WORKING] = 1'b1;
			end
		end

		// Host configuration events win over a same-cycle core clear.
		if (host_power_off_write) begin
			state_next.power_off_request = 1'b1;
		end
		state_next.power_button_mode_mirror = host_button_mode;
		if (host_button_mode != state_reg.power_button_mode_mirror) begin
			state_next.button_mode_change = 1'b1;
		end

		// Control status three; the early reset enable freezes under the lock.
		if (core_hit(core_access,
				wake_control_pkg::ADDR_CONTROL_STATUS_THREE)) begin
			state_next.control_status_three[wake_control_pkg::BIT_OVERRIDE] =
				wd[wake_control_pkg::BIT_OVERRIDE];
			if (!state_reg.config_lock) begin
				state_next.control_status_three[wake_control_pkg::BIT_EARLY_RESET] =
					wd[wake_control_pkg::BIT_EARLY_RESET];
			end
		end

		// Base address bytes, frozen under the lock, low byte kept even.
		if (!state_reg.config_lock) begin
			if (core_hit(core_access,
					wake_control_pkg::ADDR_CONFIG_BASE_LOW)) begin
				state_next.config_base_low = wd;
				state_next.config_base_low[wake_control_pkg::BIT_BASE_ALIGN] = 1'b0;
			end
			if (core_hit(core_access,
					wake_control_pkg::ADDR_CONFIG_BASE_HIGH)) begin
				state_next.config_base_high = wd;
			end
		end

		// Plain enable registers.
		if (core_hit(core_access,
				wake_control_pkg::ADDR_CORE_INTERRUPT_ENABLE_TWO)) begin
			state_next.core_interrupt_enable_two = wd;
			state_next.core_interrupt_enable_two[wake_control_pkg::BIT_WORKING] = 1'b0;
		end
		if (core_hit(core_access,
				wake_control_pkg::ADDR_CORE_EVENT_INTERRUPT_ENABLE)) begin
			state_next.core_event_interrupt_enable = wd
				& (8'h01 << wake_control_pkg::BIT_MODULE_EVENT
				| 8'h01 << wake_control_pkg::BIT_SOFTWARE_EVENT);
		end

		// Core event status: write one clears, events set afterwards and win.
		if (core_hit(core_access, wake_control_pkg::ADDR_CORE_EVENT_STATUS)) begin
			if (wd[wake_control_pkg::BIT_MODULE_EVENT]) begin
				state_next.core_event_status[wake_control_pkg::BIT_MODULE_EVENT] = 1'b0;
			end
			if (wd[wake_control_pkg::BIT_SOFTWARE_EVENT]) begin
				state_next.core_event_status[wake_control_pkg::BIT_SOFTWARE_EVENT] = 1'b0;
				core_event_clear = state_reg.clear_mode;
			end
		end
		if (core_event_clear) begin
			state_next.host_software_event = 1'b0;
		end

		// Host software event: toggle in mode 0, set in mode 1.
		if (host_access.wr && host_hit(host_access, wake_control_pkg::HOST_OFS_EVENT_STATUS)
				&& hd[wake_control_pkg::BIT_SOFTWARE_EVENT]) begin
			if (!state_reg.clear_mode) begin
				state_next.host_software_event = !state_reg.host_software_event;
			end else begin
				state_next.host_software_event = 1'b1;
			end
			event_rise = !state_reg.host_software_event;
		end
		if (event_rise) begin
			state_next.core_event_status[wake_control_pkg::BIT_SOFTWARE_EVENT] = 1'b1;
		end
		if (module_irq_event) begin
			state_next.core_event_status[wake_control_pkg::BIT_MODULE_EVENT] = 1'b1;
		end

		// Host routing enables, only bit 6 is implemented.
		if (host_access.wr
				&& host_hit(host_access, wake_control_pkg::HOST_OFS_SMI_ROUTING)) begin
			state_next.smi_routing_enable = hd
				& (8'h01 << wake_control_pkg::BIT_SOFTWARE_EVENT);
		end
		if (host_access.wr
				&& host_hit(host_access, wake_control_pkg::HOST_OFS_IRQ_ROUTING)) begin
			state_next.irq_routing_enable = hd
				& (8'h01 << wake_control_pkg::BIT_SOFTWARE_EVENT);
		end

		// Read paths, registered so the data appears one cycle after the strobe.
		ctl1 = '0;
		ctl1[wake_control_pkg::BIT_GATE_CONTROL] = state_reg.gate_control;
		ctl1[wake_control_pkg::BIT_CLEAR_MODE]   = state_reg.clear_mode;
		ctl1[wake_control_pkg::BIT_CONFIG_LOCK]  = state_reg.config_lock;
		ctl1[wake_control_pkg::BIT_BASE_VALID]   = state_reg.base_valid;
		ctl1[wake_control_pkg::BIT_BUS_RESET]    = state_reg.bus_reset_active;
		ctl1[wake_control_pkg::BIT_SUPPLY_ON]    = host_supply_on;
		ctl1[wake_control_pkg::BIT_RESET_FORCE]  = state_reg.host_reset_force;
		ctl2 = {state_reg.power_off_request, state_reg.power_button_mode_mirror,
			state_reg.state_requests};
		state_next.core_rdata = '0;
		if (core_access.rd) begin
			case (core_access.addr)
				wake_control_pkg::ADDR_CONTROL_STATUS_ONE:   state_next.core_rdata = ctl1;
				wake_control_pkg::ADDR_CONTROL_STATUS_TWO:   state_next.core_rdata = ctl2;
				wake_control_pkg::ADDR_CONTROL_STATUS_THREE:
					state_next.core_rdata = state_reg.control_status_three;
				wake_control_pkg::ADDR_CONFIG_BASE_LOW:
					state_next.core_rdata = state_reg.config_base_low;
				wake_control_pkg::ADDR_CONFIG_BASE_HIGH:
					state_next.core_rdata = state_reg.config_base_high;
				wake_control_pkg::ADDR_CORE_INTERRUPT_ENABLE_TWO:
					state_next.core_rdata = state_reg.core_interrupt_enable_two;
				wake_control_pkg::ADDR_CORE_EVENT_STATUS:
					state_next.core_rdata = state_reg.core_event_status;
				wake_control_pkg::ADDR_CORE_EVENT_INTERRUPT_ENABLE:
					state_next.core_rdata = state_reg.core_event_interrupt_enable;
				default: state_next.core_rdata = '0;
			endcase
		end
		state_next.host_rdata = '0;
		if (host_access.rd) begin
			if (host_hit(host_access, wake_control_pkg::HOST_OFS_EVENT_STATUS)) begin
				state_next.host_rdata[wake_control_pkg::BIT_SOFTWARE_EVENT] =
					state_reg.host_software_event;
			end else if (host_hit(host_access, wake_control_pkg::HOST_OFS_SMI_ROUTING)) begin
				state_next.host_rdata = state_reg.smi_routing_enable;
			end else if (host_hit(host_access, wake_control_pkg::HOST_OFS_IRQ_ROUTING)) begin
				state_next.host_rdata = state_reg.irq_routing_enable;
			end else begin
				state_next.host_rdata = '0;
			end
		end

		// Output pins; the powerdown override pulls both host lines low.
		powerdown_force = state_reg.control_status_three[wake_control_pkg::BIT_OVERRIDE]
			&& !lpc_powerdown_n;
		state_next.gate_a_twenty_output = state_reg.gate_control && !powerdown_force;
		state_next.keyboard_reset_n     = !state_reg.host_reset_force
			&& !powerdown_force;
		state_next.smi_n = !(state_reg.host_software_event
			&& state_reg.smi_routing_enable[wake_control_pkg::BIT_SOFTWARE_EVENT]);
		state_next.host_irq = state_reg.host_software_event
			&& state_reg.irq_routing_enable[wake_control_pkg::BIT_SOFTWARE_EVENT];
		state_next.state_request_wake = |state_reg.state_requests;
		state_next.status_interrupt =
			(state_reg.power_off_request
				&& state_reg.core_interrupt_enable_two[wake_control_pkg::BIT_POWER_OFF])
			|| (state_reg.button_mode_change
				&& state_reg.core_interrupt_enable_two[wake_control_pkg::BIT_BUTTON_MODE])
			|| (|(state_reg.state_requests[wake_control_pkg::BIT_SLEEP_HIGH:
				wake_control_pkg::BIT_SLEEP_LOW]
				& state_reg.core_interrupt_enable_two[wake_control_pkg::BIT_SLEEP_HIGH:
				wake_control_pkg::BIT_SLEEP_LOW]));
		state_next.event_interrupt = |(state_reg.core_event_status
			& state_reg.core_event_interrupt_enable);
		state_next.bus_reset_active = !lpc_reset_n;
		state_next.config_enable    = state_reg.base_valid;

		// Core domain reset clears only core-held controls, and not control three or the base fields.
		if (rst) begin
			state_next.gate_control                = wake_control_pkg::RESET_GATE_CONTROL;
			state_next.clear_mode                  = 1'b0;
			state_next.config_lock                 = 1'b0;
			state_next.host_reset_force            = 1'b0;
			state_next.power_off_request           = 1'b0;
			state_next.button_mode_change          = 1'b0;
			state_next.state_requests              = '0;
			state_next.core_interrupt_enable_two   = '0;
			state_next.core_event_status           = '0;
			state_next.core_event_interrupt_enable = '0;
			state_next.core_rdata                  = '0;
			state_next.gate_a_twenty_output        = 1'b1;
			state_next.keyboard_reset_n            = 1'b1;
		end

		// Supply power-up reset loads the reset values into all state; early bus traffic still
		// pulls keyboard reset so the host retries the lost cycle.
		if (supply_por) begin
			state_next = '0;
			state_next.gate_control         = wake_control_pkg::RESET_GATE_CONTROL;
			state_next.control_status_three = wake_control_pkg::RESET_CONTROL_STATUS_THREE;
			state_next.gate_a_twenty_output = 1'b1;
			state_next.smi_n                = 1'b1;
			state_next.keyboard_reset_n     = !lpc_activity;
		end
	end

	// Single state register.
	always_ff @(posedge ref_clk) begin
		state_reg <= state_next;
	end

	assign core_rdata           = state_reg.core_rdata;
	assign host_rdata           = state_reg.host_rdata;
	assign gate_a_twenty_output = state_reg.gate_a_twenty_output;
	assign keyboard_reset_n     = state_reg.keyboard_reset_n;
	assign smi_n                = state_reg.smi_n;
	assign host_irq             = state_reg.host_irq;
	assign state_request_wake   = state_reg.state_request_wake;
	assign status_interrupt     = state_reg.status_interrupt;
	assign event_interrupt      = state_reg.event_interrupt;
	assign bus_reset_active     = state_reg.bus_reset_active;
	assign config_enable        = state_reg.config_enable;
	assign config_base          = {state_reg.config_base_high, state_reg.config_base_low};

endmodule

//--- test/host_side_model.sv
`timescale 1ns/1ps
// Host chipset side.
module host_side_model (
	input  wire logic                         ref_clk,
	output wake_control_pkg::host_access_type host_access,
	input  wire logic [7:0]                   host_rdata,
	output logic                              host_power_off_write
);
	// Idle at time zero.
	initial begin
		host_access = '0;
		host_power_off_write = 1'b0;
	end

	// The caller picks the routing bank for upper offsets.
	task automatic host_write(input logic [1:0] bank, input logic [4:0] ofs, input logic [7:0] data);
		@(posedge ref_clk);
		host_access <= '{wr: 1'b1, rd: 1'b0, bank: bank, offset: ofs, wdata: data};
		@(posedge ref_clk);
		host_access.wr <= 1'b0;
	endtask

	// Read data is taken while it stands.
	task automatic host_read(input logic [1:0] bank, input logic [4:0] ofs, output logic [7:0] data);
		@(posedge ref_clk);
		host_access <= '{wr: 1'b0, rd: 1'b1, bank: bank, offset: ofs, wdata: 8'h00};
		@(posedge ref_clk);
		host_access.rd <= 1'b0;
		#1 data = host_rdata;
	endtask

	// Supply-off write pulse.
	task automatic power_off;
		@(posedge ref_clk);
		host_power_off_write <= 1'b1;
		@(posedge ref_clk);
		host_power_off_write <= 1'b0;
	endtask
endmodule

//--- test/wake_control_monitor.sv
`timescale 1ns/1ps
// Port checks of the wake block.
module wake_control_monitor (
	input wire logic                              ref_clk,
	input wire logic                              rst,
	input wire logic                              supply_por,
	input wire wake_control_pkg::core_access_type core_access,
	input wire logic [7:0]                        core_rdata,
	input wire wake_control_pkg::host_access_type host_access,
	input wire logic [7:0]                        host_rdata,
	input wire logic                              lpc_reset_n,
	input wire logic                              gate_a_twenty_output,
	input wire logic                              keyboard_reset_n,
	input wire logic                              state_request_wake,
	input wire logic                              bus_reset_active,
	input wire logic                              config_enable,
	input wire logic [15:0]                       config_base
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || supply_por);

	// Write strobes.
	logic ctl1_wr;
	logic ctl2_wr;
	logic req_wr;
	assign ctl1_wr = core_access.wr && core_access.addr == wake_control_pkg::ADDR_CONTROL_STATUS_ONE;
	assign ctl2_wr = core_access.wr && core_access.addr == wake_control_pkg::ADDR_CONTROL_STATUS_TWO;
	assign req_wr  = host_access.wr && host_access.offset == wake_control_pkg::HOST_OFS_STATE_REQUEST;

	// A full clear lands only with no host write then or next cycle.
	sequence full_clear_s;
		ctl2_wr && core_access.wdata[5:0] == 6'h3F && !host_access.wr ##1 !host_access.wr;
	endsequence

	core_idle_a: assert property (!core_access.rd |=> core_rdata == 8'h00)
		else $error("read data not idle");
	state_read_zero_a: assert property (req_wr || (host_access.rd && host_access.offset == 5'h07)
		|=> host_access.wr || host_rdata == 8'h00) else $error("request read nonzero");
	request_wake_a: assert property (req_wr |-> ##2 state_request_wake)
		else $error("no wake");
	wake_clear_a: assert property (full_clear_s |-> ##1 !state_request_wake)
		else $error("wake stuck");
	bus_reset_a: assert property (!lpc_reset_n |=> bus_reset_active)
		else $error("no bus reset flag");
	gate_low_a: assert property (ctl1_wr && !core_access.wdata[7] |-> ##2 !gate_a_twenty_output)
		else $error("gate not low");
	reset_force_a: assert property (ctl1_wr && core_access.wdata[0] |-> ##2 !keyboard_reset_n)
		else $error("no keyboard reset");
	base_align_a: assert property (config_base[0] == 1'b0)
		else $error("odd base");
	config_off_a: assert property (!config_enable)
		else $error("decode enabled");

	// Main scenarios.
	cover property (req_wr ##2 state_request_wake);
	cover property (full_clear_s);
	cover property (ctl1_wr && core_access.wdata[0]);
endmodule

bind wake_control_unit wake_control_monitor wake_control_monitor_inst (.ref_clk(ref_clk),
	.rst(rst), .supply_por(supply_por), .core_access(core_access), .core_rdata(core_rdata),
	.host_access(host_access), .host_rdata(host_rdata), .lpc_reset_n(lpc_reset_n),
	.gate_a_twenty_output(gate_a_twenty_output), .keyboard_reset_n(keyboard_reset_n),
	.state_request_wake(state_request_wake), .bus_reset_active(bus_reset_active),
	.config_enable(config_enable), .config_base(config_base));

//--- test/wake_control_unit_tb.sv
`timescale 1ns/1ps
module wake_control_unit_tb;
	logic                              ref_clk = 1'b0;
	logic                              rst = 1'b1;
	logic                              supply_por = 1'b1;
	logic                              lpc_reset_n = 1'b1;
	logic                              lpc_powerdown_n = 1'b1;
	logic                              host_button_mode = 1'b0;
	wake_control_pkg::core_access_type core_access = '0;
	wake_control_pkg::host_access_type host_access;
	logic                              host_power_off_write;
	logic [7:0]                        core_rdata, host_rdata, d;
	logic                              gate_a_twenty_output, keyboard_reset_n, smi_n, host_irq;
	logic                              state_request_wake, status_interrupt, bus_reset_active;
	logic                              config_enable, event_interrupt;
	logic [15:0]                       config_base;
	int                                fail_count = 0;
	int                                samples_checked = 0;

	// 50 ns clock.
	always #25 ref_clk = ~ref_clk;

	wake_control_unit wake_control_unit_inst (.ref_clk, .rst, .supply_por, .core_access,
		.core_rdata, .host_access, .host_rdata, .host_power_off_write, .host_button_mode,
		.module_irq_event(1'b0), .host_supply_on(1'b1), .lpc_reset_n, .lpc_powerdown_n,
		.lpc_activity(1'b0), .gate_a_twenty_output, .keyboard_reset_n, .smi_n, .host_irq,
		.state_request_wake, .status_interrupt, .event_interrupt, .bus_reset_active,
		.config_enable, .config_base);

	host_side_model host_model (.ref_clk, .host_access, .host_rdata, .host_power_off_write);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic core_write(input logic [7:0] lo, input logic [7:0] data);
		@(posedge ref_clk);
		core_access <= '{wr: 1'b1, rd: 1'b0, addr: {16'hFFF0, lo}, wdata: data};
		@(posedge ref_clk);
		core_access.wr <= 1'b0;
	endtask

	task automatic core_read(input logic [7:0] lo, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge ref_clk);
		core_access <= '{wr: 1'b0, rd: 1'b1, addr: {16'hFFF0, lo}, wdata: 8'h00};
		@(posedge ref_clk);
		core_access.rd <= 1'b0;
		#1 check(core_rdata & mask, exp);
	endtask

	// Outputs trail their cause.
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Register tests.
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		supply_por <= 1'b0;
		core_read(8'h40, 8'hFF, 8'h82);
		core_read(8'h44, 8'hFF, 8'h09);
		core_read(8'h48, 8'hFF, 8'h00);
		host_model.host_read(2'h2, 5'h13, d);
		check(d, 8'h00);
		host_model.host_read(2'h2, 5'h15, d);
		check(d, 8'h00);
		$display("reset values done");
		core_write(8'h4C, 8'h3E);
		for (int n = 1; n <= 5; n++) begin
			host_model.host_write(2'h0, 5'h07, 8'h01 << n);
			core_read(8'h42, 8'hFF, 8'h01 << n);
			check({6'h0, state_request_wake, status_interrupt}, 8'h03);
			core_write(8'h42, 8'h3F);
			settle();
			check({6'h0, state_request_wake, status_interrupt}, 8'h00);
		end
		host_model.host_write(2'h0, 5'h07, 8'h00);
		core_read(8'h42, 8'hFF, 8'h01);
		host_model.host_read(2'h0, 5'h07, d);
		check(d, 8'h00);
		core_write(8'h42, 8'h00);
		core_read(8'h42, 8'hFF, 8'h01);
		core_write(8'h42, 8'h3F);
		host_model.power_off();
		core_read(8'h42, 8'h80, 8'h80);
		core_write(8'h4C, 8'h80);
		settle();
		check({7'h0, status_interrupt}, 8'h01);
		core_write(8'h42, 8'h80);
		settle();
		check({7'h0, status_interrupt}, 8'h00);
		@(posedge ref_clk) host_button_mode <= 1'b1;
		core_write(8'h4C, 8'h40);
		core_read(8'h42, 8'h40, 8'h40);
		check({7'h0, status_interrupt}, 8'h01);
		core_write(8'h4C, 8'h00);
		settle();
		check({7'h0, status_interrupt}, 8'h00);
		$display("request latch tests done");
		core_write(8'h40, 8'h01);
		settle();
		check({6'h0, gate_a_twenty_output, keyboard_reset_n}, 8'h00);
		core_write(8'h40, 8'h80);
		core_write(8'h44, 8'h0B);
		@(posedge ref_clk) lpc_powerdown_n <= 1'b0;
		settle();
		check({6'h0, gate_a_twenty_output, keyboard_reset_n}, 8'h00);
		core_write(8'h44, 8'h09);
		settle();
		check({6'h0, gate_a_twenty_output, keyboard_reset_n}, 8'h03);
		@(posedge ref_clk) lpc_powerdown_n <= 1'b1;
		lpc_reset_n <= 1'b0;
		settle();
		check({7'h0, bus_reset_active}, 8'h01);
		core_read(8'h40, 8'h04, 8'h04);
		@(posedge ref_clk) lpc_reset_n <= 1'b1;
		$display("pin tests done");
		host_model.host_write(2'h0, 5'h00, 8'h40);
		host_model.host_read(2'h0, 5'h00, d);
		check(d & 8'h40, 8'h40);
		core_read(8'h4E, 8'h40, 8'h40);
		host_model.host_write(2'h0, 5'h00, 8'h40);
		host_model.host_read(2'h0, 5'h00, d);
		check(d & 8'h40, 8'h00);
		host_model.host_write(2'h2, 5'h13, 8'h40);
		host_model.host_write(2'h2, 5'h15, 8'h40);
		host_model.host_write(2'h0, 5'h13, 8'h00);
		host_model.host_read(2'h2, 5'h13, d);
		check(d, 8'h40);
		core_write(8'h50, 8'h40);
		host_model.host_write(2'h0, 5'h00, 8'h40);
		settle();
		check({5'h0, event_interrupt, smi_n, host_irq}, 8'h05);
		core_write(8'h40, 8'hA0);
		core_write(8'h4E, 8'h40);
		core_read(8'h4E, 8'h40, 8'h00);
		host_model.host_read(2'h0, 5'h00, d);
		check(d & 8'h40, 8'h00);
		check({5'h0, event_interrupt, smi_n, host_irq}, 8'h02);
		$display("event tests done");
		core_write(8'h48, 8'h35);
		core_read(8'h48, 8'hFF, 8'h34);
		core_write(8'h40, 8'h98);
		core_write(8'h48, 8'h10);
		core_write(8'h44, 8'h08);
		core_write(8'h40, 8'h80);
		core_read(8'h48, 8'hFF, 8'h34);
		core_read(8'h44, 8'h01, 8'h01);
		core_read(8'h40, 8'h18, 8'h10);
		check({7'h0, config_enable}, 8'h00);
		check(config_base[7:0], 8'h34);
		$display("lock tests done");
		end_of_test();
	end

	// Hang guard; tests need under a thousand cycles.
	initial begin
		repeat (4000) @(posedge ref_clk);
		fail_count++;
		end_of_test();
	end
endmodule
